// file: rtl/qdr_flash_read.sv
`timescale 1ns/1ps
`include "qdr_map.svh"

module qdr_flash_read import qdr_pkg::*; (
   input  wire logic                   clk,
   input  wire logic                   reset,
   input  wire logic                   sck_pin,          // serial clock from host
   input  wire logic                   cs_n_pin,         // chip select, low active
   input  wire logic [3:0]             io_in,            // data lines seen at pins
   output logic      [3:0]             io_out,           // data lines driven
   output logic      [3:0]             io_oe,            // high while driving a lane
   input  wire logic [7:0]             configuration_register_one,
   input  wire logic                   extended_address_bit,
   input  wire logic                   enhanced_latency_table,
   output logic      [`QDR_ADDR_W-1:0] arr_addr,         // address of next array byte
   output logic                        arr_en,           // array may stream bytes
   input  wire logic                   arr_valid,
   output logic                        arr_ready,
   input  wire logic [7:0]             arr_data,
   output logic                        execute_in_place  // continuous read armed
);

   // pin synchronisers, first stage feeds only the second
   logic             sck_s1_r, sck_s2_r, sck_s3_r;
   logic             cs_s1_r, cs_s2_r, cs_s3_r;
   logic [3:0]       io_s1_r, io_s2_r;
   logic             sck_rise, sck_fall, cs_fall, cs_rise;

   qdr_state_t       st_r;             // protocol phase
   logic [5:0]       cnt_r;            // serial clocks in current phase
   logic [7:0]       op_r;             // opcode shifter
   logic [31:0]      addr_r;           // address shifter
   logic [7:0]       mode_r;           // mode byte shifter
   logic             quad_r;           // quad output read in progress
   logic             wide_r;           // four byte address
   logic             mode_hit_r;       // mode upper nibble matched
   logic             cont_r;           // opcode skipped on next frame
   logic [`QDR_ADDR_W-1:0] arr_addr_r;
   logic [3:0]       io_out_r;
   logic [3:0]       io_oe_r;
   logic [7:0]       sh_r;             // byte being shifted out
   logic [1:0]       grp_r;            // lane groups still in sh_r

   logic [7:0]       op_nxt;
   logic [31:0]      addr_nxt;
   logic [7:0]       mode_nxt;
   logic [5:0]       addr_cyc;
   logic [5:0]       dummy_cyc;
   logic [1:0]       lat_code;
   logic             addr_done;
   logic             pop;
   logic             arr_fire;
   logic             buf_in_ready, buf_out_valid;
   logic [7:0]       buf_out_data;

   // sample the host pins, sck and cs get a third stage for edges
   always_ff @(posedge clk) begin
      if (reset) begin
         sck_s1_r <= 1'b0;
         sck_s2_r <= 1'b0;
         sck_s3_r <= 1'b0;
         cs_s1_r  <= 1'b1;
         cs_s2_r  <= 1'b1;
         cs_s3_r  <= 1'b1;
         io_s1_r  <= 4'h0;
         io_s2_r  <= 4'h0;
      end else begin
         sck_s1_r <= sck_pin;
         sck_s2_r <= sck_s1_r;
         sck_s3_r <= sck_s2_r;
         cs_s1_r  <= cs_n_pin;
         cs_s2_r  <= cs_s1_r;
         cs_s3_r  <= cs_s2_r;
         io_s1_r  <= io_in;
         io_s2_r  <= io_s1_r;
      end
   end

   // serial events, edges seen only while selected
   assign sck_rise = sck_s2_r && !sck_s3_r && !cs_s2_r;
   assign sck_fall = !sck_s2_r && sck_s3_r && !cs_s2_r;
   assign cs_fall  = !cs_s2_r && cs_s3_r;
   assign cs_rise  = cs_s2_r && !cs_s3_r;

   // shifter next values, dual lanes put the higher bit on line 1
   assign op_nxt   = {op_r[6:0], io_s2_r[0]};
   assign addr_nxt = quad_r ? {addr_r[30:0], io_s2_r[0]}
                            : {addr_r[29:0], io_s2_r[1], io_s2_r[0]};
   assign mode_nxt = {mode_r[5:0], io_s2_r[1], io_s2_r[0]};
   assign lat_code = configuration_register_one[`QDR_CFG_LAT_HI:`QDR_CFG_LAT_LO];

   // address length per command and addressing mode
   always_comb begin
      if (quad_r) begin
         addr_cyc = wide_r ? `QDR_ADDR_CYC_1L_4B : `QDR_ADDR_CYC_1L_3B;
      end else begin
         addr_cyc = wide_r ? `QDR_ADDR_CYC_2L_4B : `QDR_ADDR_CYC_2L_3B;
      end
   end

   // dummy count from the latency code
   always_comb begin
      case ({quad_r, lat_code})
         3'h4:    dummy_cyc = `QDR_QO_DUMMY_LC0;
         3'h5:    dummy_cyc = `QDR_QO_DUMMY_LC1;
         3'h6:    dummy_cyc = `QDR_QO_DUMMY_LC2;
         3'h7:    dummy_cyc = `QDR_QO_DUMMY_LC3;
         3'h0:    dummy_cyc = `QDR_DIO_DUMMY_LC0;
         3'h1:    dummy_cyc = `QDR_DIO_DUMMY_LC1;
         3'h2:    dummy_cyc = `QDR_DIO_DUMMY_LC2;
         default: dummy_cyc = `QDR_DIO_DUMMY_LC3;
      endcase
   end

   assign addr_done = (st_r == ST_ADDR) && sck_rise && !cs_rise
                      && (cnt_r == addr_cyc - 6'h01);

   // protocol phase machine, select rise wins over everything
   always_ff @(posedge clk) begin
      if (reset) begin
         st_r       <= ST_IDLE;
         cnt_r      <= 6'h00;
         op_r       <= 8'h00;
         addr_r     <= 32'h0000_0000;
         mode_r     <= 8'h00;
         quad_r     <= 1'b0;
         wide_r     <= 1'b0;
         mode_hit_r <= 1'b0;
      end else if (cs_rise) begin
         st_r <= ST_IDLE;
      end else if (cs_fall) begin
         // a continuous frame starts straight at the address
         st_r       <= cont_r ? ST_ADDR : ST_OPC;
         cnt_r      <= 6'h00;
         addr_r     <= 32'h0000_0000;
         mode_hit_r <= 1'b0;
         if (cont_r) begin
            quad_r <= 1'b0;
         end
      end else if (sck_rise) begin
         case (st_r)
            ST_OPC: begin
               op_r  <= op_nxt;
               cnt_r <= cnt_r + 6'h01;
               if (cnt_r == `QDR_OPC_CYC - 6'h01) begin
                  cnt_r <= 6'h00;
                  if ((op_nxt == `QDR_OP_QUAD_OUT || op_nxt == `QDR_OP_QUAD_OUT_WIDE)
                      && configuration_register_one[`QDR_CFG_QUAD_BIT]) begin
                     st_r   <= ST_ADDR;
                     quad_r <= 1'b1;
                     wide_r <= (op_nxt == `QDR_OP_QUAD_OUT_WIDE)
                               || extended_address_bit;
                  end else if (op_nxt == `QDR_OP_DUAL_IO
                               || op_nxt == `QDR_OP_DUAL_IO_WIDE) begin
                     st_r   <= ST_ADDR;
                     quad_r <= 1'b0;
                     wide_r <= (op_nxt == `QDR_OP_DUAL_IO_WIDE)
                               || extended_address_bit;
                  end else begin
                     st_r <= ST_IGN;  // other commands are not ours
                  end
               end
            end
            ST_ADDR: begin
               addr_r <= addr_nxt;
               cnt_r  <= cnt_r + 6'h01;
               if (addr_done) begin
                  cnt_r <= 6'h00;
                  if (!quad_r && enhanced_latency_table) begin
                     st_r <= ST_MODE;
                  end else begin
                     // no mode cycles for quad output, nor for dual without the enhanced table
                     st_r <= (dummy_cyc == 6'h00) ? ST_DATA : ST_DUMMY;
                  end
               end
            end
            ST_MODE: begin
               mode_r <= mode_nxt;
               cnt_r  <= cnt_r + 6'h01;
               if (cnt_r == `QDR_MODE_CYC - 6'h01) begin
                  cnt_r      <= 6'h00;
                  mode_hit_r <= (mode_nxt[7:4] == `QDR_MODE_CONT);
                  st_r       <= (dummy_cyc == 6'h00) ? ST_DATA : ST_DUMMY;
               end
            end
            ST_DUMMY: begin
               // line values are not looked at here
               cnt_r <= cnt_r + 6'h01;
               if (cnt_r == dummy_cyc - 6'h01) begin
                  cnt_r <= 6'h00;
                  st_r  <= ST_DATA;
               end
            end
            default: begin
               st_r <= st_r;
            end
         endcase
      end
   end

   // continuous mode is decided at each select rise; a frame that
   // ends before data (short frame, or no valid sequence) drops it
   always_ff @(posedge clk) begin
      if (reset) begin
         cont_r <= 1'b0;
      end else if (cs_rise) begin
         cont_r <= (st_r == ST_DATA) && mode_hit_r && !quad_r;
      end
   end

   // array address loads after the address phase, then counts bytes
   assign arr_fire = arr_valid && arr_ready;
   always_ff @(posedge clk) begin
      if (reset) begin
         arr_addr_r <= '0;
      end else if (addr_done) begin
         arr_addr_r <= addr_nxt[`QDR_ADDR_W-1:0];
      end else if (arr_fire) begin
         // natural overflow wraps the top address to zero
         arr_addr_r <= arr_addr_r + 1'b1;
      end
   end

   assign arr_en    = (st_r == ST_MODE) || (st_r == ST_DUMMY) || (st_r == ST_DATA);
   assign arr_ready = arr_en && buf_in_ready;
   assign pop       = (st_r == ST_DATA) && sck_fall && !cs_rise && (grp_r == 2'h0);

   // the shifter only pops when a byte is due, so the buffer fills
   qdr_buf #(
      .WIDTH (`QDR_BYTE_W),
      .DEPTH (`QDR_BUF_DEPTH)
   ) u_buf (
      .clk       (clk),
      .reset     (reset),
      .flush     (cs_rise || addr_done),
      .in_valid  (arr_valid && arr_en),
      .in_ready  (buf_in_ready),
      .in_data   (arr_data),
      .out_valid (buf_out_valid),
      .out_ready (pop),
      .out_data  (buf_out_data)
   );

   // data return on falling edges, msb first across active lanes;
   // an empty buffer zeroes only the first lane group, the rest shifts out stale storage; the array must keep up
   always_ff @(posedge clk) begin
      if (reset) begin
         io_out_r <= 4'h0;
         io_oe_r  <= 4'h0;
         sh_r     <= 8'h00;
         grp_r    <= 2'h0;
      end else if (cs_rise || st_r != ST_DATA) begin
         io_oe_r <= 4'h0;
         grp_r   <= 2'h0;
      end else if (sck_fall) begin
         if (quad_r) begin
            io_oe_r <= `QDR_OE_QUAD;
            if (grp_r == 2'h0) begin
               io_out_r <= buf_out_valid ? buf_out_data[7:4] : 4'h0;
               sh_r     <= {buf_out_data[3:0], 4'h0};
               grp_r    <= `QDR_GRP_QUAD;
            end else begin
               io_out_r <= sh_r[7:4];
               sh_r     <= {sh_r[3:0], 4'h0};
               grp_r    <= grp_r - 2'h1;
            end
         end else begin
            io_oe_r <= `QDR_OE_DUAL;
            if (grp_r == 2'h0) begin
               io_out_r <= {2'h0, buf_out_valid ? buf_out_data[7:6] : 2'h0};
               sh_r     <= {buf_out_data[5:0], 2'h0};
               grp_r    <= `QDR_GRP_DUAL;
            end else begin
               io_out_r <= {2'h0, sh_r[7:6]};
               sh_r     <= {sh_r[5:0], 2'h0};
               grp_r    <= grp_r - 2'h1;
            end
         end
      end
   end

   assign io_out           = io_out_r;
   assign io_oe            = io_oe_r;
   assign arr_addr         = arr_addr_r;
   assign execute_in_place = cont_r;

   // checks
   sequence s_cont_start;
      cs_fall && cont_r;
   endsequence

   sequence s_frame_end;
      cs_rise ##1 (st_r == ST_IDLE);
   endsequence

   a_select_ends_read: assert property (@(posedge clk) disable iff (reset)
      cs_rise |=> (st_r == ST_IDLE) ##1 (io_oe == 4'h0))
      else $error("select rise did not end the read");

   a_skip_opcode: assert property (@(posedge clk) disable iff (reset)
      s_cont_start |=> (st_r == ST_ADDR) && !quad_r)
      else $error("continuous frame did not start at address");

   a_cont_exit: assert property (@(posedge clk) disable iff (reset)
      (cs_rise && !mode_hit_r) |=> !cont_r)
      else $error("continuous mode kept without matching mode");

   a_cont_keep: assert property (@(posedge clk) disable iff (reset)
      (cs_rise && mode_hit_r && st_r == ST_DATA && !quad_r) |-> s_frame_end ##0 cont_r)
      else $error("continuous mode lost after matching mode");

   a_short_frame: assert property (@(posedge clk) disable iff (reset)
      (cs_rise && cont_r && st_r == ST_ADDR) |=> !cont_r)
      else $error("short frame did not leave continuous mode");

   a_quad_gate: assert property (@(posedge clk) disable iff (reset)
      (st_r == ST_OPC && sck_rise && !cs_rise && cnt_r == 6'h07
       && op_nxt == `QDR_OP_QUAD_OUT
       && !configuration_register_one[`QDR_CFG_QUAD_BIT]) |=> (st_r == ST_IGN))
      else $error("quad read ran without quad enable");

   a_quad_lanes: assert property (@(posedge clk) disable iff (reset)
      (io_oe != 4'h0) |-> (st_r == ST_DATA || $past(st_r) == ST_DATA)
                          && (io_oe == (quad_r ? 4'hF : 4'h3)))
      else $error("wrong lanes driven");

   a_dummy_len: assert property (@(posedge clk) disable iff (reset)
      (st_r == ST_DUMMY && sck_rise && !cs_rise)
      |=> ((st_r == ST_DATA) == ($past(cnt_r) == $past(dummy_cyc) - 6'h01)))
      else $error("dummy phase length wrong");

   a_addr_wrap: assert property (@(posedge clk) disable iff (reset)
      (arr_fire && !addr_done && arr_addr_r == '1) |=> (arr_addr_r == '0))
      else $error("array address did not wrap");

endmodule // qdr_flash_read

// file: include/qdr_map.svh
`ifndef QDR_MAP_SVH
`define QDR_MAP_SVH

// command opcodes
`define QDR_OP_QUAD_OUT        8'h6B
`define QDR_OP_QUAD_OUT_WIDE   8'h6C
`define QDR_OP_DUAL_IO         8'hBB
`define QDR_OP_DUAL_IO_WIDE    8'hBC

// mode byte upper nibble that keeps continuous read alive
`define QDR_MODE_CONT          4'hA

// configuration register one fields
`define QDR_CFG_QUAD_BIT       1
`define QDR_CFG_LAT_HI         7
`define QDR_CFG_LAT_LO         6

// serial clock cycle counts per phase
`define QDR_OPC_CYC            6'h08
`define QDR_ADDR_CYC_1L_3B     6'h18
`define QDR_ADDR_CYC_1L_4B     6'h20
`define QDR_ADDR_CYC_2L_3B     6'h0C
`define QDR_ADDR_CYC_2L_4B     6'h10
`define QDR_MODE_CYC           6'h04

// dummy cycles per latency code (plain defaults)
`define QDR_QO_DUMMY_LC0       6'h08
`define QDR_QO_DUMMY_LC1       6'h08
`define QDR_QO_DUMMY_LC2       6'h08
`define QDR_QO_DUMMY_LC3       6'h00
`define QDR_DIO_DUMMY_LC0      6'h04
`define QDR_DIO_DUMMY_LC1      6'h04
`define QDR_DIO_DUMMY_LC2      6'h04
`define QDR_DIO_DUMMY_LC3      6'h00

// data lane groups left after the first of each byte
`define QDR_GRP_QUAD           2'h1
`define QDR_GRP_DUAL           2'h3

// lane enables while returning data
`define QDR_OE_QUAD            4'hF
`define QDR_OE_DUAL            4'h3

// array address width and buffer shape
`define QDR_ADDR_W             25
`define QDR_BYTE_W             8
`define QDR_BUF_DEPTH          2

`endif

// file: include/qdr_pkg.sv
package qdr_pkg;

   // serial protocol phases
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OPC,
      ST_ADDR,
      ST_MODE,
      ST_DUMMY,
      ST_DATA,
      ST_IGN
   } qdr_state_t;

endpackage

// file: rtl/qdr_buf.sv
`timescale 1ns/1ps
`include "qdr_map.svh"

// small fifo between the array stream and the serial shifter
module qdr_buf import qdr_pkg::*; #(
   parameter int WIDTH = `QDR_BYTE_W,
   parameter int DEPTH = `QDR_BUF_DEPTH
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             flush,     // drops all held words
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_r [DEPTH];   // storage
   logic [PW-1:0]    wr_ptr_r;        // write slot
   logic [PW-1:0]    rd_ptr_r;        // read slot
   logic [PW:0]      fill_r;          // words held
   logic             push;
   logic             pop;

   // full and empty come straight from the fill count
   // compare at the count's own width, a narrower cast would alias full to empty
   assign in_ready  = (fill_r != (PW+1)'(DEPTH)) && !flush;
   assign out_valid = (fill_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready && !flush;

   // storage write, no reset needed for data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers wrap at depth
   always_ff @(posedge clk) begin
      if (reset || flush) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
      end else begin
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
      end
   end

   // fill count follows push and pop together
   always_ff @(posedge clk) begin
      if (reset || flush) begin
         fill_r <= '0;
      end else if (push && !pop) begin
         fill_r <= fill_r + 1'b1;
      end else if (pop && !push) begin
         fill_r <= fill_r - 1'b1;
      end
   end

endmodule // qdr_buf

// file: verification/qdr_host_model.sv
`timescale 1ns/1ps

// host controller on the far side of the serial link: mode 0, clock idles low between frames
module qdr_host_model (
   output logic            sck,
   output logic            cs_n,
   output logic [3:0]      host_do,    // lane values while the host drives
   output logic [3:0]      host_oe,    // high while the host drives a lane
   output logic            float_lvl,  // shown on lanes nobody drives
   input  wire logic [3:0] io_pin
);
   // 8 MHz link, well under the ceiling for both read kinds
   localparam realtime HALF = 62.5;
   logic [7:0] rx_q[$];              // bytes captured during data return
   logic [7:0] sh;                   // capture shift register

   initial begin
      sck = 1'b0;
      cs_n = 1'b1;
      host_do = 4'h0;
      host_oe = 4'h0;
      float_lvl = 1'b0;
      sh = 8'h00;
   end

   // one serial clock: host samples on the rise, everything changes after the fall
   task automatic tick(input bit cap, input int lanes);
      #HALF;
      sck = 1'b1;
      if (cap) sh = (lanes == 4) ? {sh[3:0], io_pin} : {sh[5:0], io_pin[1:0]};
      #HALF;
      sck = 1'b0;
      float_lvl = ~float_lvl;  // released lanes never hold a stale level
   endtask

   // shift a field out msb first, lane 1 carries the higher bit on two lanes
   task automatic send(input logic [31:0] v, input int nbits, input int lanes);
      for (int c = nbits / lanes - 1; c >= 0; c--) begin
         host_oe = (lanes == 1) ? 4'h1 : 4'h3;
         host_do = (lanes == 1) ? {3'b000, v[c]} : {2'b00, v[2*c+1], v[2*c]};
         tick(1'b0, lanes);
      end
   endtask

   // optional opcode, address, optional mode, dummy, then nb bytes captured
   task automatic frame(input logic [7:0] op, input bit sop, input int al, input logic [31:0] a,
                        input int ab, input bit sm, input logic [7:0] md, input int dum,
                        input int nb, input int dl);
      cs_n = 1'b0;
      if (sop) send({24'h0, op}, 8, 1);
      send(a, ab, al);
      if (sm) begin  // four mode cycles, low nibble left floating
         send({28'h0, md[7:4]}, 4, 2);
         host_oe = 4'h0;
         repeat (2) tick(1'b0, 2);
      end
      host_oe = 4'h0;  // released before the first data fall
      repeat (dum) tick(1'b0, dl);  // select held low through dummy cycles
      for (int b = 0; b < nb; b++) begin
         repeat (8 / dl) tick(1'b1, dl);
         rx_q.push_back(sh);
      end
   endtask

   // select rises half a clock after the last fall
   task automatic end_frame();
      #HALF;
      cs_n = 1'b1;
   endtask

   // eight clocks of ones: no valid request in continuous mode
   task automatic short_frame();
      cs_n = 1'b0;
      host_oe = 4'h3;
      host_do = 4'h3;
      repeat (8) tick(1'b0, 2);
      host_oe = 4'h0;
      end_frame();
   endtask
endmodule  // qdr_host_model

// file: verification/tb.sv
`timescale 1ns/1ps
`include "qdr_map.svh"

module tb;
   logic        clk, reset, sck, cs_n, float_lvl, ext, enh, stall, cont_armed;
   logic [3:0]  host_do, host_oe, io_out, io_oe, io_pin;
   logic [7:0]  cfg, arr_data;
   logic [24:0] arr_addr;
   logic        arr_en, arr_valid, arr_ready;
   int          mismatches, compares;

   // wire level from both parties' enables
   assign io_pin = (io_oe & io_out) | (~io_oe & host_oe & host_do) |
                   (~io_oe & ~host_oe & {4{float_lvl}});

   qdr_host_model i_host (.sck(sck), .cs_n(cs_n), .host_do(host_do), .host_oe(host_oe),
                          .float_lvl(float_lvl), .io_pin(io_pin));

   qdr_flash_read i_dut (.clk(clk), .reset(reset), .sck_pin(sck), .cs_n_pin(cs_n),
      .io_in(io_pin), .io_out(io_out), .io_oe(io_oe), .configuration_register_one(cfg),
      .extended_address_bit(ext), .enhanced_latency_table(enh), .arr_addr(arr_addr),
      .arr_en(arr_en), .arr_valid(arr_valid), .arr_ready(arr_ready), .arr_data(arr_data),
      .execute_in_place(cont_armed));

   always #5 clk = ~clk;

   // array contents: a pattern that differs between neighbouring bytes except across a few carries, as at 7FFF to 8000
   function automatic logic [7:0] mem(input logic [24:0] a);
      return a[7:0] ^ a[15:8] ^ a[24:17] ^ 8'h5A;
   endfunction

   // array model, random stalls only where asked so the first byte is never late
   always @(negedge clk) begin
      arr_valid <= stall ? 1'($urandom % 2) : 1'b1;
      arr_data <= mem(arr_addr);
   end

   function automatic int dummy_of(input bit q, input logic [1:0] lat);
      case (lat)
         2'd0: return q ? `QDR_QO_DUMMY_LC0 : `QDR_DIO_DUMMY_LC0;
         2'd1: return q ? `QDR_QO_DUMMY_LC1 : `QDR_DIO_DUMMY_LC1;
         2'd2: return q ? `QDR_QO_DUMMY_LC2 : `QDR_DIO_DUMMY_LC2;
         default: return q ? `QDR_QO_DUMMY_LC3 : `QDR_DIO_DUMMY_LC3;
      endcase
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // one read frame of six bytes, compared with the expected address stream
   task automatic run(input string nm, input logic [7:0] op, input bit sop, input int al,
                      input logic [31:0] a, input int ab, input bit sm, input logic [7:0] md,
                      input int dl, input logic [3:0] oe_exp);
      logic [24:0] p;
      int          dum;
      dum = dummy_of(dl == 4, cfg[`QDR_CFG_LAT_HI:`QDR_CFG_LAT_LO]);
      p = (ab == 24) ? {1'b0, a[23:0]} : a[24:0];  // short address leaves top bit zero
      i_host.rx_q.delete();
      i_host.frame(op, sop, al, a, ab, sm, md, dum, 6, dl);
      check(io_oe, oe_exp);
      if (oe_exp != 4'h0) begin
         for (int k = 0; k < 6; k++) check(i_host.rx_q[k], mem(p + 25'(k)));
      end
      i_host.end_frame();
      repeat (20) @(negedge clk);
      check(io_oe, 4'h0);
      $display("done: %s", nm);
   endtask

   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      finish_test();
   end

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      cfg = 8'h02;
      ext = 1'b0;
      enh = 1'b0;
      stall = 1'b0;
      arr_valid = 1'b0;
      arr_data = 8'h00;
      mismatches = 0;
      compares = 0;
      void'($urandom(16));
      repeat (20) @(posedge clk);
      @(negedge clk) reset = 1'b0;
      repeat (10) @(negedge clk);
      run("quad short address", 8'h6B, 1, 1, $urandom, 24, 0, 8'h00, 4, 4'hF);
      cfg = 8'hC2;  // zero dummy cycles
      run("quad wide wrap", 8'h6C, 1, 1, 32'h01FF_FFFD, 32, 0, 8'h00, 4, 4'hF);
      ext = 1'b1;
      cfg = 8'h42;
      run("quad extended", 8'h6B, 1, 1, $urandom, 32, 0, 8'h00, 4, 4'hF);
      cfg = 8'h40;  // quad enable cleared
      run("quad refused", 8'h6B, 1, 1, $urandom, 32, 0, 8'h00, 4, 4'h0);
      ext = 1'b0;
      stall = 1'b1;
      cfg = {1'b0, 1'($urandom), 6'h00};
      run("dual stalled", 8'hBB, 1, 2, $urandom, 24, 0, 8'h00, 2, 4'h3);
      stall = 1'b0;
      enh = 1'b1;
      cfg = 8'h80;
      run("dual enhanced", 8'hBC, 1, 2, $urandom, 32, 1, 8'hA5, 2, 4'h3);
      check(cont_armed, 1'b1);
      run("continuous keep", 8'h00, 0, 2, $urandom, 32, 1, 8'hA0, 2, 4'h3);
      check(cont_armed, 1'b1);
      run("continuous leave", 8'h00, 0, 2, $urandom, 32, 1, 8'h5F, 2, 4'h3);
      check(cont_armed, 1'b0);
      run("dual again", 8'hBB, 1, 2, $urandom, 24, 1, 8'hAF, 2, 4'h3);
      check(cont_armed, 1'b1);
      i_host.short_frame();
      repeat (20) @(negedge clk);
      check(cont_armed, 1'b0);
      run("after short frame", 8'hBB, 1, 2, $urandom, 24, 1, 8'h00, 2, 4'h3);
      finish_test();
   end
endmodule  // tb
